// *** sram_port.sv ***
/*
  synchronous control and address front end of a 128 K word pipelined burst sram
  assumes the array sits outside, takes mem_addr, mem_write_en, mem_byte_en and
  mem_wdata, and returns mem_rdata for mem_addr within the same cycle
*/
//
// Overview of operation
// - address sampled on edge selects word
// - low two address bits load burst counter
// - byte selects act only with write enable
// - write enable low starts a write
// - advance high steps the burst counter
// - advance low loads a new address
// - edges count only with clock qualify low
// - selected only when enables read 0-1-0
// - output enable low lets data pins drive
// - no drive in write, deselect, first cycle
// - qualify high freezes state, keeps selection
// - strap low linear, high interleaved order
// - write data captured on rising edge
`timescale 1ns/1ps
module sram_port
  import sram_port_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              advance_or_load,
  input  wire logic              clock_qualify_n,
  input  wire logic              write_enable_n,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  input  wire logic              select_a_n,
  input  wire logic              select_b,
  input  wire logic              select_c_n,
  input  wire logic              output_enable_n,
  input  wire logic              burst_order,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic [DATA_W-1:0] mem_rdata,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_write_en,
  output logic      [LANES-1:0]  mem_byte_en,
  output logic      [DATA_W-1:0] mem_wdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cmd_t              cmd;       // command held in the address stage
    logic [HI_W-1:0]   base_hi;   // upper address bits of the access
    logic [LANES-1:0]  lanes_n;   // byte selects sampled last edge
    logic              was_sel;   // selected in the cycle before
    phase_t            phase;     // data stage
    logic              read_ok;   // read not first after deselect
    logic              order;     // burst order strap copy
    logic              drive;     // internal permit to drive pins
    logic [DATA_W-1:0] dq_out;    // read data register
    logic [ADDR_W-1:0] mem_addr;  // word address to the array
    logic              wr_en;     // one-cycle write strobe
    logic [LANES-1:0]  byte_en;   // lanes written
    logic [DATA_W-1:0] wdata;     // write data register
  } port_state_t;

  port_state_t port_reg;   // registered state
  port_state_t port_next;  // next state
  logic        qual;       // a recognised clock edge
  logic        selected;   // chip enables decode to selected
  burst_if     bi ();      // link to the burst sequencer

  assign qual     = !clock_qualify_n;
  assign selected = !select_a_n && select_b && !select_c_n;

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  // load on advance low
  assign bi.load    = qual && !advance_or_load;
  assign bi.advance = qual && advance_or_load;
  assign bi.start   = addr_in[BURST_W-1:0];
  assign bi.linear  = !port_reg.order;

  burst_seq u_seq (
    .clock (clock),
    .rst   (rst),
    .bus   (bi.seq)
  );

  // next state; nothing moves without a qualified edge, so a held
  // clock qualify stretches the cycle instead of deselecting
  always_comb
  begin
    port_next       = port_reg;
    // the write strobe is a pulse so a frozen cycle cannot write twice
    port_next.wr_en = 1'h0;
    if (qual)
    begin
      port_next.order   = burst_order;
      port_next.lanes_n = byte_lane_write_n;
      // data stage: follows the address stage by one edge
      unique case (port_reg.cmd)
        CMD_WRITE:
        begin
          port_next.phase    = PH_WRITE;
          port_next.mem_addr = {port_reg.base_hi, bi.low};
          port_next.wr_en    = 1'h1;
          port_next.byte_en  = ~port_reg.lanes_n;
          port_next.wdata    = dq_in;
        end
        CMD_READ:
        begin
          port_next.phase    = PH_READ;
          port_next.mem_addr = {port_reg.base_hi, bi.low};
        end
        CMD_DESEL:
        begin
          port_next.phase    = PH_IDLE;
        end
        // the unused code behaves as deselect, so nothing is written or driven
        default:
        begin
          port_next.phase    = PH_IDLE;
        end
      endcase
      port_next.read_ok = port_reg.was_sel;
      port_next.drive   = (port_reg.phase == PH_READ) && port_reg.read_ok;
      if (port_reg.phase == PH_READ)
        port_next.dq_out = mem_rdata;
      port_next.was_sel = (port_reg.cmd != CMD_DESEL);
      // address stage: a load takes a fresh command, an advance keeps it
      if (!advance_or_load)
      begin
        if (!selected)
          port_next.cmd = CMD_DESEL;
        else if (!write_enable_n)
          port_next.cmd = CMD_WRITE;
        else
          port_next.cmd = CMD_READ;
        port_next.base_hi = addr_in[ADDR_W-1:BURST_W];
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      port_reg <= '{cmd: CMD_DESEL, base_hi: '0, lanes_n: LANES_IDLE, was_sel: 1'h0,
                    phase: PH_IDLE, read_ok: 1'h0, order: ORDER_RESET, drive: 1'h0,
                    dq_out: DATA_RESET, mem_addr: ADDR_RESET, wr_en: 1'h0,
                    byte_en: LANES_OFF, wdata: DATA_RESET};
    else
      port_reg <= port_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dq_out       = port_reg.dq_out;
  assign dq_oe_n      = output_enable_n || !port_reg.drive;
  assign mem_addr     = port_reg.mem_addr;
  assign mem_write_en = port_reg.wr_en;
  assign mem_byte_en  = port_reg.byte_en;
  assign mem_wdata    = port_reg.wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_select_decode: assert property (
    (qual && !advance_or_load && !selected) |=> port_reg.cmd == CMD_DESEL ##1 !mem_write_en)
    else $error("deselected load still produced a write");
  chk_write_strobe: assert property (
    (qual && port_reg.cmd == CMD_WRITE) |=> mem_write_en && port_reg.phase == PH_WRITE)
    else $error("write command gave no strobe");
  chk_lane_qualify: assert property (
    (qual && port_reg.cmd == CMD_WRITE) |=> mem_byte_en == ~$past(port_reg.lanes_n))
    else $error("byte lanes not taken from sampled selects");
  chk_freeze_hold: assert property (
    clock_qualify_n |=> $stable(port_reg.cmd) && $stable(mem_addr) && !mem_write_en)
    else $error("state moved on an unqualified edge");
  chk_upper_addr: assert property (
    (qual && port_reg.cmd != CMD_DESEL)
      |=> mem_addr[ADDR_W-1:BURST_W] == $past(port_reg.base_hi))
    else $error("burst altered upper address bits");
  chk_wdata_capture: assert property (
    (qual && port_reg.cmd == CMD_WRITE) |=> mem_wdata == $past(dq_in))
    else $error("write data not captured");
  chk_no_drive: assert property (
    (qual && (port_reg.phase != PH_READ || !port_reg.read_ok)) |=> dq_oe_n)
    else $error("pins driven outside a proper read");
  chk_oe_gate: assert property (
    !dq_oe_n |-> !output_enable_n && $past(port_reg.phase) == PH_READ && $past(port_reg.read_ok))
    else $error("pins driven without output enable and a proper read");
  chk_strap_copy: assert property (qual |=> port_reg.order == $past(burst_order))
    else $error("burst order strap not followed");
  chk_address_load: assert property (
    (qual && !advance_or_load) |=> port_reg.base_hi == $past(addr_in[ADDR_W-1:BURST_W]))
    else $error("new address not loaded");

  cov_write: cover property (qual && port_reg.cmd == CMD_WRITE ##1 mem_write_en);
  cov_read_drive: cover property (!dq_oe_n);
  cov_freeze: cover property (port_reg.cmd == CMD_READ && clock_qualify_n [*3]);
  cov_burst: cover property (qual && advance_or_load && port_reg.cmd != CMD_DESEL [*3]);
endmodule

// *** sram_port_pkg.sv ***
/*
  constants and types shared by the burst sram control front end
  assumes one 40 MHz clock and a memory array outside this block
*/
package sram_port_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 17;  // 128 K word locations
  localparam int BURST_W    = 2;   // two-bit burst counter
  localparam int HI_W       = ADDR_W - BURST_W;
  localparam int LANES      = 4;   // byte lanes a..d
  localparam int LANE_W     = 9;   // eight data bits plus parity
  localparam int DATA_W     = LANES * LANE_W;
  localparam int CLOCK_NS   = 25;  // 40 MHz period

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic              ORDER_RESET = 1'h1;  // interleaved until strap is read
  localparam logic [BURST_W-1:0] STEP_RESET = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE   = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET  = 36'h000000000;
  localparam logic [LANES-1:0]  LANES_IDLE  = 4'hf;   // active low, none selected
  localparam logic [LANES-1:0]  LANES_OFF   = 4'h0;   // active high, none enabled

  // ----------------------------------------------------------------
  // command held in the address stage and phase of the data stage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_DESEL = 2'h0,
    CMD_READ  = 2'h1,
    CMD_WRITE = 2'h3
  } cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_READ  = 2'h1,
    PH_WRITE = 2'h3
  } phase_t;
endpackage

// *** burst_if.sv ***
/*
  carrier between the control front end and its burst sequencer
  assumes both ends run on the same clock
*/
`timescale 1ns/1ps
interface burst_if;
  import sram_port_pkg::*;
  logic               load;     // take a new start offset
  logic               advance;  // step the burst
  logic [BURST_W-1:0] start;    // low address bits at load
  logic               linear;   // high for linear order
  logic [BURST_W-1:0] low;      // current low address bits

  modport ctrl (output load, output advance, output start, output linear, input low);
  modport seq  (input load, input advance, input start, input linear, output low);
endinterface

// *** burst_seq.sv ***
/*
  two-bit burst sequencer: linear or interleaved order inside a four word group
  assumes load and advance are already qualified by the clock enable
*/
`timescale 1ns/1ps
module burst_seq
  import sram_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  burst_if.seq     bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BURST_W-1:0] start;  // offset loaded with the address
    logic [BURST_W-1:0] step;   // words taken since the load
  } seq_state_t;

  seq_state_t seq_reg;   // registered state
  seq_state_t seq_next;  // next state

  // next state: load wins over advance, step wraps in two bits
  always_comb
  begin
    seq_next = seq_reg;
    if (bus.load)
    begin
      seq_next.start = bus.start;
      seq_next.step  = STEP_RESET;
    end
    else if (bus.advance)
    begin
      seq_next.step = seq_reg.step + STEP_ONE;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      seq_reg <= '{start: STEP_RESET, step: STEP_RESET};
    else
      seq_reg <= seq_next;
  end

  assign bus.low = bus.linear ? seq_reg.start + seq_reg.step : seq_reg.start ^ seq_reg.step;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_load_start: assert property (bus.load |=> bus.low == $past(bus.start))
    else $error("burst low bits differ from loaded start");
  chk_linear_step: assert property (
    (bus.advance && !bus.load && bus.linear && $stable(bus.linear))
      |=> bus.low == BURST_W'($past(bus.low) + STEP_ONE))
    else $error("linear burst did not step by one");
  // interleaved order: the low bits change by the exclusive or of two successive step codes
  chk_interleave_step: assert property (
    (bus.advance && !bus.load && !bus.linear && $stable(bus.linear))
      |=> (bus.low ^ $past(bus.low))
          == ($past(seq_reg.step) ^ BURST_W'($past(seq_reg.step) + STEP_ONE)))
    else $error("interleaved burst order wrong");
endmodule

// *** sram_array_model.sv ***
/*
  behavioural word array behind the burst sram front end
  assumes mem_addr is settled before each rising edge of clock
*/
`timescale 1ns/1ps
module sram_array_model
  import sram_port_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_write_en,
  input  wire logic [LANES-1:0]  mem_byte_en,
  input  wire logic [DATA_W-1:0] mem_wdata,
  output logic      [DATA_W-1:0] mem_rdata
);
  // ------------------------------------------------------------
  // storage, one word per address
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];  // unwritten words stay unknown

  assign mem_rdata = mem[mem_addr];

  always @(posedge clock)
  begin
    if (mem_write_en)
      for (int i = 0; i < LANES; i++)
        if (mem_byte_en[i])
          mem[mem_addr][LANE_W*i +: LANE_W] <= mem_wdata[LANE_W*i +: LANE_W];
  end
endmodule

// *** tb_top.sv ***
/*
  self-checking bench for the burst sram front end
  assumes sram_array_model stands behind the array ports
*/
`timescale 1ns/1ps
module tb_top
  import sram_port_pkg::*;
;
  // ------------------------------------------------------------
  // pins and counters
  // ------------------------------------------------------------
  localparam logic [2:0] SEL = 3'h2;  // select pins read 0,1,0
  logic              clock, rst, adv, q_n, we_n, oe_n, order, dq_oe_n, mem_write_en;
  logic [2:0]        sel;
  logic [LANES-1:0]  lanes_n, mem_byte_en;
  logic [ADDR_W-1:0] addr, mem_addr;
  logic [DATA_W-1:0] dq_in, dq_out, mem_rdata, mem_wdata, lane_exp;
  int                errors, n_compared;

  sram_port DUT (.clock(clock), .rst(rst), .addr_in(addr), .advance_or_load(adv),
    .clock_qualify_n(q_n), .write_enable_n(we_n), .byte_lane_write_n(lanes_n),
    .select_a_n(sel[2]), .select_b(sel[1]), .select_c_n(sel[0]),
    .output_enable_n(oe_n), .burst_order(order), .dq_in(dq_in), .mem_rdata(mem_rdata),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .mem_addr(mem_addr), .mem_write_en(mem_write_en),
    .mem_byte_en(mem_byte_en), .mem_wdata(mem_wdata));
  sram_array_model model (.clock(clock), .mem_addr(mem_addr), .mem_write_en(mem_write_en),
    .mem_byte_en(mem_byte_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  // 25 ns clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // one cycle: inputs change 1 ns after an edge, return 1 ns after the next
  task cyc(input logic qn, input logic ad, input logic wn, input logic [2:0] s,
           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    q_n = qn;
    adv = ad;
    we_n = wn;
    sel = s;
    addr = a;
    dq_in = d;
    @(posedge clock);
    #1;
  endtask

  // released data lines show the inverse of their last value
  task desel();
    cyc(1'b0, 1'b0, 1'b1, 3'h7, addr, ~dq_in);
  endtask

  function automatic logic [DATA_W-1:0] wd(input int k);
    wd = 36'h9a5c3e0f1 + DATA_W'(k) * 36'h010101011;
  endfunction

  function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] a, input logic lin,
                                              input logic [1:0] k);
    baddr = {a[ADDR_W-1:2], lin ? a[1:0] + k : a[1:0] ^ k};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // four word write burst, strap chooses the order
  task sc_burst(input logic lin, input logic [ADDR_W-1:0] a);
    order = ~lin;
    oe_n = 1'b0;  // output enable low, so only the write mask can hold the pins off
    desel();
    cyc(1'b0, 1'b0, 1'b0, SEL, a, ~dq_in);
    for (int k = 1; k < 4; k++)
      cyc(1'b0, 1'b1, 1'b0, SEL, ~a, wd(k - 1));
    chk("drive in write", 36'h1, {35'h0, dq_oe_n});
    cyc(1'b0, 1'b0, 1'b1, 3'h7, a, wd(3));
    desel();
    desel();
    for (int k = 0; k < 4; k++)
      chk("burst word", wd(k), model.mem[baddr(a, lin, 2'(k))]);
  endtask

  // partial lane write merges into the old word
  task sc_lanes(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] nw;  // word offered on the data lines
    nw = wd(9);
    lane_exp = model.mem[a];
    lanes_n = 4'h5;
    for (int i = 0; i < LANES; i++)
      if (!lanes_n[i])
        lane_exp[LANE_W*i +: LANE_W] = nw[LANE_W*i +: LANE_W];
    desel();
    cyc(1'b0, 1'b0, 1'b0, SEL, a, ~dq_in);
    cyc(1'b0, 1'b0, 1'b1, 3'h7, a, wd(9));
    desel();
    desel();
    lanes_n = 4'h0;
    chk("lane merge", lane_exp, model.mem[a]);
  endtask

  // each wrong select, and a read with lanes low, leave the word alone
  task sc_refuse(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] old;
    logic [2:0]        pat [4];
    old = model.mem[a];
    pat = '{3'h6, 3'h0, 3'h3, SEL};
    for (int j = 0; j < 4; j++)
    begin
      desel();
      cyc(1'b0, 1'b0, j == 3, pat[j], a, ~dq_in);
      cyc(1'b0, 1'b0, 1'b1, 3'h7, a, 36'h0ffff0000);
      desel();
      desel();
      chk("refused write", old, model.mem[a]);
    end
  endtask

  // two reads after deselect: first stays off the pins, second drives
  task sc_read(input logic [ADDR_W-1:0] a);
    oe_n = 1'b0;
    desel();
    cyc(1'b0, 1'b0, 1'b1, SEL, a, ~dq_in);
    cyc(1'b0, 1'b0, 1'b1, SEL, a, ~dq_in);
    desel();
    chk("drive after deselect", 36'h1, {35'h0, dq_oe_n});
    desel();
    chk("drive on read", 36'h0, {35'h0, dq_oe_n});
    chk("read data", lane_exp, dq_out);
    oe_n = 1'b1;
    #1;
    chk("output gate", 36'h1, {35'h0, dq_oe_n});
    oe_n = 1'b0;
    desel();
    chk("drive deselected", 36'h1, {35'h0, dq_oe_n});
  endtask

  // masked edges between command and data change nothing
  task sc_freeze(input logic [ADDR_W-1:0] a);
    desel();
    cyc(1'b0, 1'b0, 1'b0, SEL, a, ~dq_in);
    for (int k = 0; k < 3; k++)
    begin
      cyc(1'b1, 1'b1, 1'b1, 3'h7, ~a, ~dq_in);
      chk("frozen strobe", 36'h0, {35'h0, mem_write_en});
    end
    cyc(1'b0, 1'b0, 1'b1, 3'h7, a, wd(7));
    desel();
    desel();
    chk("write after freeze", wd(7), model.mem[a]);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    {rst, adv, q_n, we_n, oe_n, order} = 6'h37;
    sel = 3'h7;
    lanes_n = 4'h0;
    addr = '0;
    dq_in = '0;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    sc_burst(1'b1, 17'h12342);
    sc_burst(1'b0, 17'h0abc1);
    sc_lanes(17'h12342);
    sc_refuse(17'h0abc1);
    sc_read(17'h12342);
    sc_freeze(17'h1f00f);
    end_of_test();
  end

  initial
  begin
    #(CLOCK_NS * 2000);
    errors++;
    end_of_test();
  end
endmodule
